// [rtl/tws_bus_ctrl.v]
// two-wire slave bus control: start/stop, address, general call,
// high-speed entry, acknowledge, read termination and bus timeout
// assumes: scl/sda/address pins are asynchronous; tx data and the
// address acquire request come from logic on core_clk_in
`include "tws_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module tws_bus_ctrl #(
    parameter              TO_W           = `TWS_TIMEOUT_W,
    parameter [TO_W-1:0]   TIMEOUT_CYCLES = `TWS_TIMEOUT_CYCLES
)(
    input  wire       core_clk_in,      // core clock, 20 MHz
    input  wire       arst_n_in,        // async reset, active low
    input  wire       scl_in,           // scl pin level
    input  wire       sda_in,           // sda pin level
    input  wire       addr_sel_pin_0,   // address select pin, lowest
    input  wire       addr_sel_pin_1,   // address select pin, middle
    input  wire       addr_sel_pin_2,   // address select pin, highest
    input  wire       addr_acquire_in,  // request to re-sample pins
    input  wire [7:0] tx_data_in,       // byte to send on a read
    output reg        scl_out,          // scl drive level, always 0
    output reg        scl_oe_n_out,     // scl enable, active low, never on
    output reg        sda_out,          // sda drive level, always 0
    output reg        sda_oe_n_out,     // sda enable, active low
    output reg  [6:0] slave_addr_out,   // latched seven-bit address
    output reg        hs_mode_out,      // filters in high-speed mode
    output reg        regs_reset_out,   // pulse: registers to power-up
    output reg  [7:0] rx_data_out,      // received write byte
    output reg        rx_valid_out,     // pulse: rx_data_out new
    output reg        tx_take_out,      // pulse: tx_data_in taken
    output reg        busy_out,         // inside a frame
    output reg        timeout_out       // pulse: bus timeout fired
);

    localparam [2:0] ST_IDLE   = `TWS_ST_IDLE;
    localparam [2:0] ST_RECV   = `TWS_ST_RECV;
    localparam [2:0] ST_ACK    = `TWS_ST_ACK;
    localparam [2:0] ST_SEND   = `TWS_ST_SEND;
    localparam [2:0] ST_MACK   = `TWS_ST_MACK;
    localparam [2:0] ST_IGNORE = `TWS_ST_IGNORE;

    // compose slave address from pin levels
    function [6:0] make_addr;
        input [2:0] pins;
        begin
            make_addr = {`TWS_ADDR_FIXED, pins};
        end
    endfunction

    wire [4:0]      pins_s;
    reg             scl_d;
    reg             sda_d;
    reg  [2:0]      state;
    reg  [2:0]      after_ack;
    reg  [1:0]      phase;
    reg  [3:0]      bit_cnt;
    reg  [7:0]      shreg;
    reg  [7:0]      txreg;
    reg             first_byte;
    reg             mack_ok;
    reg  [2:0]      init_sh;
    reg             gc_relatch;
    reg  [TO_W-1:0] to_cnt;

    // ==========================================================
    // pin synchronisation
    tws_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk_in    (core_clk_in),
        .arst_n_in (arst_n_in),
        .async_in  ({addr_sel_pin_2, addr_sel_pin_1, addr_sel_pin_0,
                     sda_in, scl_in}),
        .sync_out  (pins_s)
    );

    wire scl_s   = pins_s[0];
    wire sda_s   = pins_s[1];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
    wire line_low  = ~scl_s | ~sda_s;
    wire to_hit    = busy_out & line_low & (to_cnt == TIMEOUT_CYCLES);
    wire init_done = init_sh[2];  // sync holds real pin levels by now
    wire latch_req = ~init_done | start_det | addr_acquire_in | gc_relatch;
    wire byte_done = scl_fall & (bit_cnt == `TWS_BITS_PER_BYTE);

    // ==========================================================
    // edge history
    always @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // ==========================================================
    // address pin latch
    always @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            init_sh        <= 3'h0;
            slave_addr_out <= make_addr(3'h0);
        end
        else
        begin
            // keep latching for three edges: the sync shows reset-high first
            init_sh <= {init_sh[1:0], 1'b1};
            if (latch_req)
                slave_addr_out <= make_addr(pins_s[4:2]);
        end
    end

    // ==========================================================
    // stuck-line counter inside a frame
    always @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            to_cnt <= {TO_W{1'b0}};
        else if (busy_out & line_low & ~to_hit)
            to_cnt <= to_cnt + {{(TO_W-1){1'b0}}, 1'b1};
        else
            to_cnt <= {TO_W{1'b0}};
    end

    // ==========================================================
    // serial state machine
    always @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state          <= ST_IDLE;
            after_ack      <= ST_IGNORE;
            phase          <= `TWS_PH_ADDR;
            bit_cnt        <= `TWS_BIT_ZERO;
            shreg          <= 8'h00;
            txreg          <= 8'h00;
            first_byte     <= 1'b0;
            mack_ok        <= 1'b0;
            gc_relatch     <= 1'b0;
            scl_out        <= 1'b0;
            scl_oe_n_out   <= 1'b1;
            sda_out        <= 1'b0;
            sda_oe_n_out   <= 1'b1;
            hs_mode_out    <= 1'b0;
            regs_reset_out <= 1'b0;
            rx_data_out    <= 8'h00;
            rx_valid_out   <= 1'b0;
            tx_take_out    <= 1'b0;
            busy_out       <= 1'b0;
            timeout_out    <= 1'b0;
        end
        else
        begin
            gc_relatch     <= 1'b0;
            regs_reset_out <= 1'b0;
            rx_valid_out   <= 1'b0;
            tx_take_out    <= 1'b0;
            timeout_out    <= 1'b0;
            if (stop_det)
            begin
                state        <= ST_IDLE;
                sda_oe_n_out <= 1'b1;
                busy_out     <= 1'b0;
                hs_mode_out  <= 1'b0;
            end
            else if (to_hit)
            begin
                state        <= ST_IDLE;
                sda_oe_n_out <= 1'b1;
                busy_out     <= 1'b0;
                timeout_out  <= 1'b1;
            end
            else if (start_det)
            begin
                state        <= ST_RECV;
                phase        <= `TWS_PH_ADDR;
                bit_cnt      <= `TWS_BIT_ZERO;
                first_byte   <= 1'b1;
                sda_oe_n_out <= 1'b1;
                busy_out     <= 1'b1;
            end
            else
            begin
                case (state)
                    ST_RECV:
                    begin
                        if (scl_rise)
                        begin
                            shreg   <= {shreg[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (byte_done)
                        begin
                            first_byte <= 1'b0;
                            bit_cnt    <= `TWS_BIT_ZERO;
                            state      <= ST_IGNORE;
                            case (phase)
                                `TWS_PH_ADDR:
                                begin
                                    if (first_byte && shreg[7:3] == `TWS_HS_CODE)
                                        hs_mode_out <= 1'b1;
                                    else if (shreg[7:1] == slave_addr_out)
                                    begin
                                        state        <= ST_ACK;
                                        sda_oe_n_out <= 1'b0;
                                        after_ack    <= shreg[0] ? ST_SEND : ST_RECV;
                                        phase        <= `TWS_PH_WR;
                                    end
                                    else if (shreg == {`TWS_GC_ADDR, 1'b0})
                                    begin
                                        state        <= ST_ACK;
                                        sda_oe_n_out <= 1'b0;
                                        after_ack    <= ST_RECV;
                                        phase        <= `TWS_PH_GC;
                                    end
                                end
                                `TWS_PH_GC:
                                begin
                                    if (shreg == `TWS_GC_LATCH ||
                                        shreg == `TWS_GC_RESET)
                                    begin
                                        state          <= ST_ACK;
                                        sda_oe_n_out   <= 1'b0;
                                        after_ack      <= ST_IGNORE;
                                        gc_relatch     <= 1'b1;
                                        regs_reset_out <= (shreg == `TWS_GC_RESET);
                                    end
                                end
                                default:
                                begin
                                    state        <= ST_ACK;
                                    sda_oe_n_out <= 1'b0;
                                    after_ack    <= ST_RECV;
                                    rx_data_out  <= shreg;
                                    rx_valid_out <= 1'b1;
                                end
                            endcase
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            state   <= after_ack;
                            bit_cnt <= `TWS_BIT_ZERO;
                            if (after_ack == ST_SEND)
                            begin
                                txreg        <= tx_data_in;
                                tx_take_out  <= 1'b1;
                                sda_oe_n_out <= tx_data_in[7];
                            end
                            else
                                sda_oe_n_out <= 1'b1;
                        end
                    end
                    ST_SEND:
                    begin
                        if (scl_rise)
                            bit_cnt <= bit_cnt + 4'h1;
                        else if (byte_done)
                        begin
                            state        <= ST_MACK;
                            sda_oe_n_out <= 1'b1;
                            mack_ok      <= 1'b0;
                        end
                        else if (scl_fall)
                        begin
                            sda_oe_n_out <= txreg[6];
                            txreg        <= {txreg[6:0], 1'b0};
                        end
                    end
                    ST_MACK:
                    begin
                        if (scl_rise)
                            mack_ok <= ~sda_s;
                        else if (scl_fall)
                        begin
                            bit_cnt <= `TWS_BIT_ZERO;
                            if (mack_ok)
                            begin
                                state        <= ST_SEND;
                                txreg        <= tx_data_in;
                                tx_take_out  <= 1'b1;
                                sda_oe_n_out <= tx_data_in[7];
                            end
                            else
                                state <= ST_IGNORE;
                        end
                    end
                    ST_IDLE, ST_IGNORE:
                        sda_oe_n_out <= 1'b1;
                    default:
                    begin
                        state        <= ST_IDLE;
                        sda_oe_n_out <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// [common/tws_defs.vh]
// constants for the two-wire slave bus control block
// assumes: included by bare name from rtl files; definitions only
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH

// core clock and bus timeout
`define TWS_CLK_KHZ         20000
`define TWS_TIMEOUT_US      54000
`define TWS_TIMEOUT_CYCLES  ((`TWS_TIMEOUT_US * `TWS_CLK_KHZ) / 1000)
`define TWS_TIMEOUT_W       21

// byte framing
`define TWS_BITS_PER_BYTE   4'h8
`define TWS_BIT_ZERO        4'h0

// address decode
`define TWS_ADDR_FIXED      4'h9
`define TWS_GC_ADDR         7'h00
`define TWS_HS_CODE         5'h01
`define TWS_GC_LATCH        8'h04
`define TWS_GC_RESET        8'h06

// serial state machine codes
`define TWS_ST_IDLE         3'h0
`define TWS_ST_RECV         3'h1
`define TWS_ST_ACK          3'h2
`define TWS_ST_SEND         3'h3
`define TWS_ST_MACK         3'h4
`define TWS_ST_IGNORE       3'h5

// kind of byte being received
`define TWS_PH_ADDR         2'h0
`define TWS_PH_GC           2'h1
`define TWS_PH_WR           2'h2

`endif

// [rtl/tws_sync.v]
// two flip-flop synchroniser for a group of pin levels
// assumes: inputs are asynchronous to clk_in; only sync_out is read outside
`timescale 1ns/10ps
`default_nettype none

module tws_sync #(
    parameter WIDTH = 5
)(
    input  wire             clk_in,     // core clock
    input  wire             arst_n_in,  // async reset, active low
    input  wire [WIDTH-1:0] async_in,   // raw pin levels
    output wire [WIDTH-1:0] sync_out    // synchronised levels
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    // ==========================================================
    // two stages, reset to bus-idle high
    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            stage1 <= {WIDTH{1'b1}};
            stage2 <= {WIDTH{1'b1}};
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;

endmodule

`default_nettype wire

// [tb/tws_bus_monitor.sv]
// checker for the port behaviour of the two-wire slave bus control
// assumes: bound into tws_bus_ctrl; scl_in/sda_in carry resolved wire levels
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// checker
module tws_bus_monitor #(
    parameter TO_W           = 21,
    parameter TIMEOUT_CYCLES = 1080000
)(
    input wire logic       core_clk_in,    // core clock
    input wire logic       arst_n_in,      // reset, active low
    input wire logic       scl_in,         // scl wire level
    input wire logic       sda_in,         // sda wire level
    input wire logic       scl_oe_n_out,   // scl enable, active low
    input wire logic       sda_oe_n_out,   // sda enable, active low
    input wire logic [6:0] slave_addr_out, // latched address
    input wire logic       hs_mode_out,    // high-speed filters
    input wire logic       regs_reset_out, // register reset pulse
    input wire logic       busy_out,       // inside a frame
    input wire logic       timeout_out     // timeout pulse
);
    logic [31:0] low_run;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    // cycles since both lines were last high together
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            low_run <= 32'h0000_0000;
        else if (scl_in && sda_in)
            low_run <= 32'h0000_0000;
        else
            low_run <= low_run + 32'h0000_0001;
    end
    property p_idle_free; !busy_out && scl_in && sda_in |-> sda_oe_n_out; endproperty
    a_idle_free: assert property (p_idle_free) else $error("sda driven on idle bus");
    property p_scl_free; scl_oe_n_out; endproperty
    a_scl_free: assert property (p_scl_free) else $error("scl driven");
    property p_addr_form; slave_addr_out[6:3] == 4'h9; endproperty
    a_addr_form: assert property (p_addr_form) else $error("address upper bits wrong");
    property p_hs_end; $fell(hs_mode_out) |-> scl_in && sda_in && !busy_out; endproperty
    a_hs_end: assert property (p_hs_end) else $error("high speed left without stop");
    property p_to_count; timeout_out |-> low_run >= TIMEOUT_CYCLES; endproperty
    a_to_count: assert property (p_to_count) else $error("timeout too early");
    property p_to_free; timeout_out |=> (sda_oe_n_out && !busy_out) [*3]; endproperty
    a_to_free: assert property (p_to_free) else $error("bus held after timeout");
    property p_ack_hold; $changed(sda_oe_n_out) && busy_out |-> !scl_in; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("sda moved while scl high");
    property p_gc_pulse; regs_reset_out |-> busy_out ##1 !regs_reset_out; endproperty
    a_gc_pulse: assert property (p_gc_pulse) else $error("register reset pulse bad");
    property p_start_busy; $rose(busy_out) |-> !sda_in; endproperty
    a_start_busy: assert property (p_start_busy) else $error("frame without start");
    property p_stop_idle; $fell(busy_out) |-> sda_in || timeout_out || $past(timeout_out);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("frame ended without stop");
endmodule
bind tws_bus_ctrl tws_bus_monitor #(.TO_W(TO_W), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon_inst (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .scl_oe_n_out(scl_oe_n_out), .sda_oe_n_out(sda_oe_n_out),
    .slave_addr_out(slave_addr_out), .hs_mode_out(hs_mode_out),
    .regs_reset_out(regs_reset_out), .busy_out(busy_out), .timeout_out(timeout_out));
`default_nettype wire

// [tb/tws_master_model.sv]
// behavioural two-wire bus master driving open-drain scl and sda
// assumes: drive 1 releases a line; wire levels resolved by the bench
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// master model
module tws_master_model (
    input  wire logic core_clk_in, // core clock
    input  wire logic sda_in,      // resolved sda wire
    output var logic  scl_drv_out, // scl drive, 1 releases
    output var logic  sda_drv_out  // sda drive, 1 releases
);
    // lines released, clock stands still outside frames
    initial
    begin
        scl_drv_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    task automatic lk(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    // one 400 ns bit: sda moves only while scl low
    task automatic put_bit(input logic b, output logic s);
        lk(2);
        sda_drv_out <= b;
        lk(3);
        scl_drv_out <= 1'b1;
        lk(2);
        s = sda_in;
        lk(1);
        scl_drv_out <= 1'b0;
    endtask
    // start or repeated start
    task automatic start();
        lk(2);
        sda_drv_out <= 1'b1;
        lk(2);
        scl_drv_out <= 1'b1;
        lk(3);
        sda_drv_out <= 1'b0;
        lk(4);
        scl_drv_out <= 1'b0;
    endtask
    // stop, leaves bus idle
    task automatic stop();
        lk(2);
        sda_drv_out <= 1'b0;
        lk(3);
        scl_drv_out <= 1'b1;
        lk(3);
        sda_drv_out <= 1'b1;
        lk(4);
    endtask
    // byte out, msb first, ack slot released
    task automatic tx_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], s);
        put_bit(1'b1, ack);
    endtask
    // byte in; nack high ends a read
    task automatic rx_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(nack, s);
    endtask
endmodule
`default_nettype wire

// [tb/tws_bus_ctrl_bench.sv]
// self-checking bench for the two-wire slave bus control
// assumes: master model on the link, small timeout count of 200 cycles
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench
module tws_bus_ctrl_bench;
    logic       core_clk_in = 1'b0;
    logic       arst_n_in;
    logic       acq;
    logic [2:0] pins;
    logic [7:0] tx;
    logic       scl_o, scl_oe_n, sda_o, sda_oe_n, hs, rr, rxv, txt, busy, tmo, m_scl, m_sda, a;
    logic [6:0] addr;
    logic [7:0] rxd, last_rx, d;
    wire        scl_w = m_scl & (scl_oe_n | scl_o);
    wire        sda_w = m_sda & (sda_oe_n | sda_o);
    int         n_rx = 0, n_rr = 0, n_to = 0, n_tx = 0, miscompares = 0, n_compared = 0;
    always #25 core_clk_in = ~core_clk_in;
    tws_bus_ctrl #(.TIMEOUT_CYCLES(21'd200)) tws_bus_ctrl_inst (.core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in), .scl_in(scl_w), .sda_in(sda_w), .addr_sel_pin_0(pins[0]),
        .addr_sel_pin_1(pins[1]), .addr_sel_pin_2(pins[2]), .addr_acquire_in(acq),
        .tx_data_in(tx), .scl_out(scl_o), .scl_oe_n_out(scl_oe_n), .sda_out(sda_o),
        .sda_oe_n_out(sda_oe_n), .slave_addr_out(addr), .hs_mode_out(hs),
        .regs_reset_out(rr), .rx_data_out(rxd), .rx_valid_out(rxv), .tx_take_out(txt),
        .busy_out(busy), .timeout_out(tmo));
    tws_master_model tws_master_model_inst (.core_clk_in(core_clk_in), .sda_in(sda_w),
        .scl_drv_out(m_scl), .sda_drv_out(m_sda));
    // counts of the design's one-cycle pulses
    always @(posedge core_clk_in)
    begin
        if (rxv === 1'b1) begin n_rx <= n_rx + 1; last_rx <= rxd; end
        if (rr === 1'b1) n_rr <= n_rr + 1;
        if (tmo === 1'b1) n_to <= n_to + 1;
        if (txt === 1'b1) n_tx <= n_tx + 1;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // byte out and judge the ack slot (0 on the wire = ack)
    task automatic wbyte(input logic [7:0] v, input logic ack);
        tws_master_model_inst.tx_byte(v, a);
        check("ack slot", a, !ack);
    endtask
    task automatic t_write();
        int r0 = n_rx;
        tws_master_model_inst.start();
        wbyte({4'h9, pins, 1'b0}, 1'b1);
        wbyte(8'hA5, 1'b1);
        check("rx byte", last_rx, 8'hA5);
        wbyte(8'h3C, 1'b1);
        wbyte(8'hF0, 1'b1);
        check("rx count", n_rx - r0, 3);
        tws_master_model_inst.stop();
        check("busy after stop", busy, 1'b0);
        tws_master_model_inst.start();
        wbyte({4'h9, ~pins, 1'b0}, 1'b0);
        wbyte(8'h55, 1'b0);
        tws_master_model_inst.stop();
        check("rx after foreign", n_rx - r0, 3);
    endtask
    task automatic t_read();
        int t0 = n_tx;
        tws_master_model_inst.start();
        wbyte({4'h9, pins, 1'b1}, 1'b1);
        fork
            tws_master_model_inst.rx_byte(1'b0, d);
            begin tws_master_model_inst.lk(20); tx <= 8'h3C; end
        join
        check("read byte 1", d, 8'h96);
        tws_master_model_inst.rx_byte(1'b1, d);
        check("read byte 2", d, 8'h3C);
        check("tx takes", n_tx - t0, 2);
        tws_master_model_inst.put_bit(1'b1, a);
        check("sda after nack", a, 1'b1);
        tws_master_model_inst.stop();
    endtask
    // general call: latch, latch with reset, bad command, read direction
    task automatic t_gc();
        int r0 = n_rr;
        tws_master_model_inst.start();
        pins <= 3'b011;
        wbyte(8'h00, 1'b1);
        wbyte(8'h04, 1'b1);
        check("addr after 04", addr, 7'h4B);
        check("reset after 04", n_rr - r0, 0);
        tws_master_model_inst.start();
        pins <= 3'b110;
        wbyte(8'h00, 1'b1);
        wbyte(8'h06, 1'b1);
        check("addr after 06", addr, 7'h4E);
        check("reset after 06", n_rr - r0, 1);
        tws_master_model_inst.start();
        pins <= 3'b001;
        wbyte(8'h00, 1'b1);
        wbyte(8'h05, 1'b0);
        check("addr after 05", addr, 7'h4E);
        tws_master_model_inst.start();
        wbyte(8'h01, 1'b0);
        tws_master_model_inst.stop();
        check("reset count", n_rr - r0, 1);
        pins <= 3'b111;
        tws_master_model_inst.lk(4);
        acq <= 1'b1;
        tws_master_model_inst.lk(2);
        acq <= 1'b0;
        tws_master_model_inst.lk(4);
        check("addr after acquire", addr, 7'h4F);
    endtask
    task automatic t_hs();
        logic [7:0] codes [2] = '{8'h08, 8'h0F};
        foreach (codes[k])
        begin
            tws_master_model_inst.start();
            wbyte(codes[k], 1'b0);
            check("hs after code", hs, 1'b1);
            tws_master_model_inst.start();
            wbyte({4'h9, pins, 1'b0}, 1'b1);
            check("hs after restart", hs, 1'b1);
            tws_master_model_inst.stop();
            check("hs after stop", hs, 1'b0);
        end
    endtask
    task automatic t_timeout();
        int o0 = n_to;
        tws_master_model_inst.start();
        for (int i = 7; i >= 0; i--)
            tws_master_model_inst.put_bit(i == 0 ? 1'b0 : (i > 3 ? 1'b1 : 1'b1), a);
        tws_master_model_inst.lk(150);
        check("no early timeout", n_to - o0, 0);
        tws_master_model_inst.lk(110);
        check("timeout count", n_to - o0, 1);
        check("sda released", sda_oe_n, 1'b1);
        check("busy after timeout", busy, 1'b0);
        tws_master_model_inst.start();
        wbyte({4'h9, pins, 1'b0}, 1'b1);
        tws_master_model_inst.stop();
    endtask
    // watchdog on the whole run
    initial
    begin
        repeat (100000) @(posedge core_clk_in);
        miscompares++;
        finish_test();
    end
    initial
    begin
        // reset asserted and inputs set before the first edge
        arst_n_in <= 1'b0;
        acq <= 1'b0;
        pins <= 3'b101;
        tx <= 8'h96;
        repeat (11) @(posedge core_clk_in);
        check("addr in reset", addr, 7'h48);
        check("sda enable in reset", sda_oe_n, 1'b1);
        @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        repeat (6) @(posedge core_clk_in);
        check("addr from pins", addr, 7'h4D);
        t_write();
        t_read();
        t_gc();
        t_hs();
        pins <= 3'b100;
        t_timeout();
        finish_test();
    end
endmodule
`default_nettype wire
